/* rtl/usbd_flag_bank.sv */
// bank of sticky event flags, one flip-flop per bit
// assumes one clock; set beats clear so no event is lost
module usbd_flag_bank #(
  parameter int W = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  usbd_flag_if.bank flags
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags.q <= '0;
    end else begin
      flags.q <= (flags.q & ~flags.clr) | flags.set;
    end
  end
endmodule

/* rtl/usbd_flag_if.sv */
// set/clear/state bundle between the register block and its sticky flag bank
// assumes set and clear are one-cycle pulses in the clk domain
interface usbd_flag_if #(
  parameter int W = 8
);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;

  modport owner (output set, output clr, input  q);
  modport bank  (input  set, input  clr, output q);
endinterface

/* rtl/usbd_pkg.sv */
// constants for the usb device port state-control block
// assumes a byte-addressed register port with 32-bit words on aligned offsets
package usbd_pkg;
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam int          NUM_EP           = 6;

  // register byte offsets
  localparam logic [7:0]  OFF_FRAME_NUMBER = 8'h00;
  localparam logic [7:0]  OFF_GLOBAL_STATE = 8'h04;
  localparam logic [7:0]  OFF_FUNC_ADDRESS = 8'h08;
  localparam logic [7:0]  OFF_INT_ENABLE   = 8'h10;
  localparam logic [7:0]  OFF_INT_DISABLE  = 8'h14;
  localparam logic [7:0]  OFF_INT_MASK     = 8'h18;
  localparam logic [7:0]  OFF_INT_STATUS   = 8'h1C;
  localparam logic [7:0]  OFF_INT_CLEAR    = 8'h20;
  localparam logic [7:0]  OFF_EP_RESET     = 8'h28;
  localparam logic [7:0]  OFF_EP_CSR_BASE  = 8'h30;
  localparam logic [7:0]  OFF_EP_FIFO_BASE = 8'h50;
  localparam logic [7:0]  EP_STRIDE        = 8'h04;
  localparam logic [7:0]  EP_SPAN          = 8'(NUM_EP * 4);
  localparam logic [7:0]  OFF_XCVR_CTRL    = 8'h74;

  // field positions
  localparam int          GS_ADDR_EN_BIT   = 0;
  localparam int          GS_CONFIG_BIT    = 1;
  localparam int          FA_ADDR_W        = 7;
  localparam int          FA_FEN_BIT       = 8;
  localparam int          FN_COUNT_W       = 11;
  localparam int          FN_ERR_BIT       = 16;
  localparam int          FN_GOOD_BIT      = 17;
  localparam int          XC_DISABLE_BIT   = 8;
  localparam int          XC_PULLUP_BIT    = 9;

  // interrupt status and mask bits
  localparam int          IS_W             = 14;
  localparam int          IS_SUSPEND       = 8;
  localparam int          IS_RESUME        = 9;
  localparam int          IS_EXT_RESUME    = 10;
  localparam int          IS_FRAME_START   = 11;
  localparam int          IS_BUS_RESET_END = 12;
  localparam int          IS_WAKEUP        = 13;
  localparam logic [13:0] IS_VALID         = 14'h3F3F;

  // reset values
  localparam logic [31:0] FUNC_ADDRESS_RST = 32'h0000_0100;
  localparam logic [13:0] INT_MASK_RST     = 14'h1200;

  // timing
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          SUSPEND_IDLE_US  = 3000;
  localparam int          SUSPEND_IDLE_CYC = (CLK_HZ / 1_000_000) * SUSPEND_IDLE_US;
endpackage

/* rtl/usbd_state_ctrl.sv */
// usb device port state control: attach, bus reset, address, configured,
// suspend and resume tracking, frame number capture and the register map
// assumes packet-layer strobes are synchronous to clk; bus_active may be
// asynchronous and is synchronised here
module usbd_state_ctrl
  import usbd_pkg::*;
#(
  parameter int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [DATA_W-1:0]     reg_rdata,
  input  wire logic                  bus_active,
  input  wire logic                  bus_reset_done,
  input  wire logic                  sof_pid_seen,
  input  wire logic                  sof_packet_end,
  input  wire logic [FN_COUNT_W-1:0] sof_frame,
  input  wire logic                  sof_crc_error,
  input  wire logic [NUM_EP-1:0]     ep_event,
  input  wire logic                  ext_resume_req,
  output logic                       irq,
  output logic                       pullup_connect,
  output logic                       transceiver_disable,
  output logic                       address_state,
  output logic                       configured,
  output logic                       function_enable,
  output logic      [FA_ADDR_W-1:0]  function_addr,
  output logic                       port_suspended,
  output logic      [NUM_EP-1:0]     ep_reset
);

  typedef enum logic [1:0] {
    LINK_ACTIVE,
    LINK_SUSP_PEND,
    LINK_SUSPENDED
  } usbd_link_e;

  usbd_link_e              link_state;
  usbd_link_e              next_link_state;
  logic [31:0]             idle_count;
  logic                    act_meta;
  logic                    act_sync;
  logic [IS_W-1:0]         int_mask;
  logic [FN_COUNT_W-1:0]   frame_count;
  logic                    frame_good;
  logic                    frame_error;
  logic [DATA_W-1:0]       ep_csr  [NUM_EP];
  logic [DATA_W-1:0]       ep_fifo [NUM_EP];

  // status bits live in the flag bank; the mask stays here beside the decode
  usbd_flag_if #(.W(IS_W)) status_flags ();

  usbd_flag_bank #(
    .W     (IS_W)
  ) u_status (
    .clk   (clk),
    .rst_n (rst_n),
    .flags (status_flags)
  );

  // address decode
  wire             wr_global  = reg_write && (reg_addr == OFF_GLOBAL_STATE);
  wire             wr_faddr   = reg_write && (reg_addr == OFF_FUNC_ADDRESS);
  wire             wr_ier     = reg_write && (reg_addr == OFF_INT_ENABLE);
  wire             wr_idr     = reg_write && (reg_addr == OFF_INT_DISABLE);
  wire             wr_icr     = reg_write && (reg_addr == OFF_INT_CLEAR);
  wire             wr_rst_ep  = reg_write && (reg_addr == OFF_EP_RESET);
  wire             wr_txvc    = reg_write && (reg_addr == OFF_XCVR_CTRL);
  wire [7:0]       csr_off    = reg_addr - OFF_EP_CSR_BASE;
  wire [7:0]       fifo_off   = reg_addr - OFF_EP_FIFO_BASE;
  wire             csr_hit    = (reg_addr >= OFF_EP_CSR_BASE) && (csr_off < EP_SPAN)
                                && (reg_addr[1:0] == 2'h0);
  wire             fifo_hit   = (reg_addr >= OFF_EP_FIFO_BASE) && (fifo_off < EP_SPAN)
                                && (reg_addr[1:0] == 2'h0);
  wire [2:0]       csr_idx    = csr_off[4:2];
  wire [2:0]       fifo_idx   = fifo_off[4:2];
  wire             wr_csr     = reg_write && csr_hit;
  wire             wr_fifo    = reg_write && fifo_hit;
  wire [IS_W-1:0]  wdata_is   = reg_wdata[IS_W-1:0] & IS_VALID;

  // link activity: synchronised so a resume is caught even from a parked bus
  wire             idle_done  = (idle_count >= 32'(SUSPEND_IDLE_CYCLES - 1));
  wire             in_suspend = (link_state != LINK_ACTIVE);
  wire             suspend_ev = (link_state == LINK_ACTIVE) && !act_sync && idle_done;
  wire             resume_ev  = in_suspend && act_sync;

  // end of bus reset overrides every link state, so a reset seen while
  // pending or suspended still lands in the active state
  always_comb begin
    next_link_state = link_state;
    unique case (link_state)
      LINK_ACTIVE: begin
        if (suspend_ev) begin
          next_link_state = LINK_SUSP_PEND;
        end
      end
      LINK_SUSP_PEND: begin
        if (resume_ev) begin
          next_link_state = LINK_ACTIVE;
        end else if (wr_icr && reg_wdata[IS_SUSPEND]) begin
          next_link_state = LINK_SUSPENDED;
        end
      end
      LINK_SUSPENDED: begin
        if (resume_ev) begin
          next_link_state = LINK_ACTIVE;
        end
      end
    endcase
    if (bus_reset_done) begin
      next_link_state = LINK_ACTIVE;
    end
  end

  // two-flop synchroniser; only act_sync is read downstream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_meta <= 1'b0;
      act_sync <= 1'b0;
    end else begin
      act_meta <= bus_active;
      act_sync <= act_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_state <= LINK_ACTIVE;
    end else begin
      link_state <= next_link_state;
    end
  end

  // idle counter saturates at the threshold; any activity restarts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_count <= 32'h0000_0000;
    end else if (act_sync || bus_reset_done || in_suspend) begin
      idle_count <= 32'h0000_0000;
    end else if (!idle_done) begin
      idle_count <= idle_count + 32'h0000_0001;
    end
  end

  // taken from the next state so the pin moves on the acknowledging edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_suspended <= 1'b0;
    end else begin
      port_suspended <= (next_link_state == LINK_SUSPENDED);
    end
  end

  // status flag events; the bank lets a set beat a clear in the same cycle
  wire [IS_W-1:0] evt_bus_reset = IS_W'(1) << IS_BUS_RESET_END;
  wire [IS_W-1:0] evt_suspend   = IS_W'(1) << IS_SUSPEND;
  wire [IS_W-1:0] evt_resume    = (IS_W'(1) << IS_RESUME) | (IS_W'(1) << IS_WAKEUP);
  wire [IS_W-1:0] evt_ext_rsm   = IS_W'(1) << IS_EXT_RESUME;
  wire [IS_W-1:0] evt_frame     = IS_W'(1) << IS_FRAME_START;

  assign status_flags.set = IS_W'(ep_event)
                          | (bus_reset_done ? evt_bus_reset : '0)
                          | (suspend_ev     ? evt_suspend   : '0)
                          | (resume_ev      ? evt_resume    : '0)
                          | (ext_resume_req ? evt_ext_rsm   : '0)
                          | (sof_pid_seen   ? evt_frame     : '0);
  assign status_flags.clr = wr_icr ? wdata_is : '0;

  // mask register: enable and disable writes, restored by bus reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= INT_MASK_RST;
    end else if (bus_reset_done) begin
      int_mask <= INT_MASK_RST;
    end else if (wr_ier) begin
      int_mask <= int_mask | wdata_is;
    end else if (wr_idr) begin
      int_mask <= int_mask & ~wdata_is;
    end
  end

  // end of bus reset interrupts whatever the mask holds
  wire irq_next = (|(status_flags.q & int_mask))
                || status_flags.q[IS_BUS_RESET_END];

  // registered so the pin never glitches while flags and mask update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // device state bits: address enable only ever set by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      address_state   <= 1'b0;
      configured      <= 1'b0;
      function_enable <= FUNC_ADDRESS_RST[FA_FEN_BIT];
      function_addr   <= FUNC_ADDRESS_RST[FA_ADDR_W-1:0];
    end else if (bus_reset_done) begin
      address_state   <= 1'b0;
      configured      <= 1'b0;
      function_enable <= FUNC_ADDRESS_RST[FA_FEN_BIT];
      function_addr   <= FUNC_ADDRESS_RST[FA_ADDR_W-1:0];
    end else begin
      if (wr_global) begin
        address_state <= address_state | reg_wdata[GS_ADDR_EN_BIT];
        configured    <= reg_wdata[GS_CONFIG_BIT];
      end
      if (wr_faddr) begin
        function_enable <= reg_wdata[FA_FEN_BIT];
        function_addr   <= reg_wdata[FA_ADDR_W-1:0];
      end
    end
  end

  // transceiver control survives bus reset; the pull-up must stay in suspend
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_connect      <= 1'b0;
      transceiver_disable <= 1'b0;
    end else if (wr_txvc) begin
      pullup_connect      <= reg_wdata[XC_PULLUP_BIT];
      transceiver_disable <= reg_wdata[XC_DISABLE_BIT];
    end
  end

  // endpoint reset bits hold their words at zero until software or end of bus reset lowers them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_reset <= '0;
    end else if (bus_reset_done) begin
      ep_reset <= '0;
    end else if (wr_rst_ep) begin
      ep_reset <= reg_wdata[NUM_EP-1:0];
    end
  end

  // endpoint control/status and data holding words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_csr[i]  <= 32'h0000_0000;
        ep_fifo[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (bus_reset_done || ep_reset[i]) begin
          ep_csr[i]  <= 32'h0000_0000;
          ep_fifo[i] <= 32'h0000_0000;
        end else begin
          if (wr_csr && (csr_idx == 3'(i))) begin
            ep_csr[i] <= reg_wdata;
          end
          if (wr_fifo && (fifo_idx == 3'(i))) begin
            ep_fifo[i] <= reg_wdata;
          end
        end
      end
    end
  end

  // frame number capture; a packet end beats the next identifier's clear
  wire frame_end_good = sof_packet_end && !sof_crc_error;
  wire frame_end_bad  = sof_packet_end && sof_crc_error;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_count <= '0;
      frame_good  <= 1'b0;
      frame_error <= 1'b0;
    end else begin
      if (sof_packet_end) begin
        frame_count <= sof_frame;
      end
      frame_good  <= frame_end_good || (frame_good && !sof_pid_seen);
      frame_error <= frame_end_bad  || (frame_error && !sof_pid_seen);
    end
  end

  // read selection; unmapped and write-only offsets read zero
  wire [DATA_W-1:0] rd_frame  = {14'h0000, frame_good, frame_error, 5'h00, frame_count};
  wire [DATA_W-1:0] rd_global = {30'h0000_0000, configured, address_state};
  wire [DATA_W-1:0] rd_faddr  = {23'h00_0000, function_enable, 1'b0, function_addr};
  wire [DATA_W-1:0] rd_mask   = {18'h0_0000, int_mask};
  wire [DATA_W-1:0] rd_status = {18'h0_0000, status_flags.q};
  wire [DATA_W-1:0] rd_rst_ep = {26'h000_0000, ep_reset};
  wire [DATA_W-1:0] rd_txvc   = {22'h00_0000, pullup_connect, transceiver_disable, 8'h00};
  wire [DATA_W-1:0] rd_sel    =
      (reg_addr == OFF_FRAME_NUMBER) ? rd_frame  :
      (reg_addr == OFF_GLOBAL_STATE) ? rd_global :
      (reg_addr == OFF_FUNC_ADDRESS) ? rd_faddr  :
      (reg_addr == OFF_INT_MASK)     ? rd_mask   :
      (reg_addr == OFF_INT_STATUS)   ? rd_status :
      (reg_addr == OFF_EP_RESET)     ? rd_rst_ep :
      (reg_addr == OFF_XCVR_CTRL)    ? rd_txvc   :
      csr_hit                        ? ep_csr[csr_idx]   :
      fifo_hit                       ? ep_fifo[fifo_idx] :
      32'h0000_0000;

  // zero outside the answer cycle, so a late sample never sees a stale word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? rd_sel : 32'h0000_0000;
    end
  end

endmodule

/* test/usbd_host_model.sv */
// behavioural host port seen through the packet-layer strobes
// assumes each task is entered in the time step of a rising clk edge
module usbd_host_model
  import usbd_pkg::*;
(
  input  wire logic                  clk,
  output logic                       bus_active,
  output logic                       bus_reset_done,
  output logic                       sof_pid_seen,
  output logic                       sof_packet_end,
  output logic      [FN_COUNT_W-1:0] sof_frame,
  output logic                       sof_crc_error
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bus_active = 1'b1;
    bus_reset_done = 1'b0;
    sof_pid_seen = 1'b0;
    sof_packet_end = 1'b0;
    sof_frame = '0;
    sof_crc_error = 1'b0;
  end
  // traffic stops to ask for suspend and restarts to resume
  task automatic set_active(input logic a);
    bus_active <= a;
  endtask
  task automatic bus_reset();
    bus_reset_done <= 1'b1;
    @(posedge clk);
    bus_reset_done <= 1'b0;
  endtask
  // frame and error mean nothing outside the end strobe, so they churn
  task automatic sof(input logic [FN_COUNT_W-1:0] fr, input logic err, input int gap);
    sof_pid_seen <= 1'b1;
    @(posedge clk);
    sof_pid_seen <= 1'b0;
    repeat (gap) begin
      sof_frame <= ~sof_frame;
      sof_crc_error <= ~sof_crc_error;
      @(posedge clk);
    end
    sof_packet_end <= 1'b1;
    sof_frame <= fr;
    sof_crc_error <= err;
    @(posedge clk);
    sof_packet_end <= 1'b0;
    sof_frame <= ~fr;
    sof_crc_error <= ~err;
  endtask
  // remote wakeup in scaled clk cycles; the k state shows up as bus activity
  task automatic remote_wakeup(input int wait_cyc, input int hold_cyc);
    repeat (wait_cyc) @(posedge clk);
    bus_active <= 1'b1;
    repeat (hold_cyc) @(posedge clk);
  endtask
endmodule

/* test/usbd_state_ctrl_monitor.sv */
// port-level checks for the usb device state-control block
// assumes one clock domain and an asynchronous active-low reset
module usbd_state_ctrl_monitor
  import usbd_pkg::*;
#(
  parameter int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_CYC
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [DATA_W-1:0]     reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [DATA_W-1:0]     reg_rdata,
  input wire logic                  bus_active,
  input wire logic                  bus_reset_done,
  input wire logic                  sof_pid_seen,
  input wire logic                  sof_packet_end,
  input wire logic [FN_COUNT_W-1:0] sof_frame,
  input wire logic                  sof_crc_error,
  input wire logic [NUM_EP-1:0]     ep_event,
  input wire logic                  ext_resume_req,
  input wire logic                  irq,
  input wire logic                  pullup_connect,
  input wire logic                  transceiver_disable,
  input wire logic                  address_state,
  input wire logic                  configured,
  input wire logic                  function_enable,
  input wire logic [FA_ADDR_W-1:0]  function_addr,
  input wire logic                  port_suspended,
  input wire logic [NUM_EP-1:0]     ep_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data not zero outside a read answer");
  AST_RESERVED_RD: assert property (reg_read && reg_addr == 8'h0C |=> reg_rdata == '0)
    else $error("reserved word read not zero");
  AST_BUSRST_IRQ: assert property (bus_reset_done ##1 !reg_write |=> irq)
    else $error("no interrupt after end of bus reset");
  AST_BUSRST_STATE: assert property (bus_reset_done && !reg_write |=>
      !address_state && !configured && function_enable && function_addr == '0 && ep_reset == '0)
    else $error("bus reset did not restore device state");
  AST_FRAME_UPD: assert property (sof_packet_end ##1 (reg_read && reg_addr == OFF_FRAME_NUMBER
      && !sof_pid_seen) |=> reg_rdata[FN_COUNT_W-1:0] == $past(sof_frame, 2)
      && reg_rdata[FN_ERR_BIT] == $past(sof_crc_error, 2)
      && reg_rdata[FN_GOOD_BIT] == !$past(sof_crc_error, 2))
    else $error("frame word not taken at packet end");
  AST_SUSP_ACK: assert property ($rose(port_suspended) |-> $past(reg_write)
      && $past(reg_addr) == OFF_INT_CLEAR && $past(reg_wdata[IS_SUSPEND]))
    else $error("suspend entered without acknowledge");
  AST_RESUME: assert property (port_suspended && $rose(bus_active) |-> ##[1:4] !port_suspended)
    else $error("bus activity did not end suspend");
  AST_XCVR_WR: assert property (reg_write && reg_addr == OFF_XCVR_CTRL |=>
      pullup_connect == $past(reg_wdata[XC_PULLUP_BIT])
      && transceiver_disable == $past(reg_wdata[XC_DISABLE_BIT]))
    else $error("transceiver control outputs wrong");
  AST_ADDR_EN: assert property (reg_write && reg_addr == OFF_GLOBAL_STATE
      && reg_wdata[GS_ADDR_EN_BIT] && !bus_reset_done |=> address_state)
    else $error("address state not entered");
endmodule

bind usbd_state_ctrl usbd_state_ctrl_monitor #(.SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)) u_mon (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .bus_active,
  .bus_reset_done, .sof_pid_seen, .sof_packet_end, .sof_frame, .sof_crc_error, .ep_event,
  .ext_resume_req, .irq, .pullup_connect, .transceiver_disable, .address_state, .configured,
  .function_enable, .function_addr, .port_suspended, .ep_reset
);

/* test/usbd_state_ctrl_tb_top.sv */
// self-checking bench for the usb device state-control block
// assumes the host model drives the packet strobes and the bench plays firmware
module usbd_state_ctrl_tb_top
  import usbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SUSP = 20;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  reg_write = 1'b0;
  logic                  reg_read = 1'b0;
  logic [ADDR_W-1:0]     reg_addr = '0;
  logic [DATA_W-1:0]     reg_wdata = '0;
  logic [NUM_EP-1:0]     ep_event = '0;
  logic                  ext_resume_req = 1'b0;
  logic [DATA_W-1:0]     reg_rdata;
  logic                  irq, pullup_connect, transceiver_disable, address_state, configured;
  logic                  function_enable, port_suspended, bus_active, bus_reset_done;
  logic                  sof_pid_seen, sof_packet_end, sof_crc_error;
  logic [FN_COUNT_W-1:0] sof_frame;
  logic [FA_ADDR_W-1:0]  function_addr;
  logic [NUM_EP-1:0]     ep_reset;
  logic [31:0]           imr = 32'h0000_1200, isr = '0, frm = '0, gs = '0, txvc = '0, f;
  logic [31:0]           fa = 32'h0000_0100;
  logic [31:0]           mem [int];
  int                    miscompares = 0, num_checks = 0;

  always #20 clk = ~clk;

  usbd_state_ctrl #(.SUSPEND_IDLE_CYCLES(SUSP)) dut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .bus_active,
    .bus_reset_done, .sof_pid_seen, .sof_packet_end, .sof_frame, .sof_crc_error, .ep_event,
    .ext_resume_req, .irq, .pullup_connect, .transceiver_disable, .address_state,
    .configured, .function_enable, .function_addr, .port_suspended, .ep_reset
  );
  usbd_host_model host (
    .clk, .bus_active, .bus_reset_done, .sof_pid_seen, .sof_packet_end, .sof_frame,
    .sof_crc_error
  );

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic is_ep(input logic [7:0] a);
    return a[1:0] == 2'b00 && (a >= OFF_EP_CSR_BASE && a < OFF_EP_CSR_BASE + EP_SPAN
      || a >= OFF_EP_FIFO_BASE && a < OFF_EP_FIFO_BASE + EP_SPAN);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      OFF_FRAME_NUMBER: return frm;
      OFF_GLOBAL_STATE: return gs;
      OFF_FUNC_ADDRESS: return fa;
      OFF_INT_MASK:     return imr;
      OFF_INT_STATUS:   return isr;
      OFF_XCVR_CTRL:    return txvc;
      default:          return mem.exists(a) ? mem[a] : '0;
    endcase
  endfunction
  // one idle cycle after each strobe keeps a signal to one change per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    case (a)
      OFF_GLOBAL_STATE: gs = {30'b0, d[1], gs[0] | d[0]};
      OFF_FUNC_ADDRESS: fa = d & 32'h0000_017F;
      OFF_INT_ENABLE:   imr = imr | (d & 32'h0000_3F3F);
      OFF_INT_DISABLE:  imr = imr & ~d;
      OFF_INT_CLEAR:    isr = isr & ~d;
      OFF_XCVR_CTRL:    txvc = d & 32'h0000_0300;
      OFF_EP_RESET: begin
        mem[a] = d & 32'h0000_003F;
        for (int i = 0; i < NUM_EP; i++) begin
          if (d[i]) begin
            mem.delete(OFF_EP_CSR_BASE + 8'(4 * i));
            mem.delete(OFF_EP_FIFO_BASE + 8'(4 * i));
          end
        end
      end
      default:          if (is_ep(a)) mem[a] = d;
    endcase
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp_rd(a));
    if (a == OFF_INT_STATUS) chk(32'(irq), 32'(|(isr & imr) | isr[IS_BUS_RESET_END]));
    @(posedge clk);
  endtask
  task automatic rd_all();
    for (int a = 0; a < 128; a += 4) begin
      if (8'(a) != OFF_INT_STATUS) rd(8'(a));
    end
  endtask
  task automatic wait_lvl(input logic which, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      if ((which ? port_suspended : irq) === v) break;
    end
    @(posedge clk);
    if (n == 200) begin
      miscompares++;
      $display("MISMATCH %0t wait ran out", $time);
      stop_test();
    end
  endtask

  initial begin
    void'($urandom(32'h0000_444B));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_all();
    rd(8'h05);
    wr(OFF_XCVR_CTRL, 32'h0000_0100);
    chk(32'({pullup_connect, transceiver_disable}), 32'h0000_0001);
    wr(OFF_INT_CLEAR, 32'h0000_3F3F);
    wr(OFF_XCVR_CTRL, 32'h0000_0300);
    chk(32'(pullup_connect), 32'h0000_0001);
    for (int i = 0; i < NUM_EP; i++) begin
      wr(OFF_EP_CSR_BASE + 8'(4 * i), $urandom());
      wr(OFF_EP_FIFO_BASE + 8'(4 * i), $urandom());
    end
    wr(8'h0C, $urandom());
    wr(OFF_INT_ENABLE, $urandom() & 32'h0000_2F3F);
    wr(OFF_GLOBAL_STATE, 32'h0000_0003);
    wr(OFF_FUNC_ADDRESS, $urandom());
    wr(OFF_EP_RESET, $urandom());
    rd_all();
    host.bus_reset();
    imr = 32'h0000_1200;
    isr = isr | 32'h0000_1000;
    gs = '0;
    fa = 32'h0000_0100;
    mem.delete();
    rd_all();
    rd(OFF_INT_STATUS);
    wr(OFF_EP_CSR_BASE, 32'h0000_8000);
    wr(OFF_INT_ENABLE, 32'h0000_0001);
    wr(OFF_XCVR_CTRL, 32'h0000_0200);
    wr(OFF_INT_CLEAR, 32'h0000_1000);
    rd(OFF_INT_STATUS);
    f = 32'($urandom_range(127, 1));
    wr(OFF_GLOBAL_STATE, 32'h0000_0001);
    wr(OFF_FUNC_ADDRESS, 32'h0000_0100 | f);
    chk({address_state, function_enable, 23'b0, function_addr}, {2'b11, 23'b0, f[6:0]});
    wr(OFF_GLOBAL_STATE, 32'h0000_0002);
    chk(32'({configured, address_state}), 32'h0000_0003);
    rd(OFF_GLOBAL_STATE);
    for (int i = 0; i < 4; i++) begin
      f = 32'($urandom_range(2047, 0));
      frm = frm & 32'h0000_07FF;
      isr = isr | 32'h0000_0800;
      fork
        host.sof(f[10:0], i[0], 6);
        begin
          repeat (2) @(posedge clk);
          rd(OFF_FRAME_NUMBER);
        end
      join
      frm = f | (i[0] ? 32'h0001_0000 : 32'h0002_0000);
      rd(OFF_FRAME_NUMBER);
    end
    f = $urandom();
    ep_event <= f[5:0];
    ext_resume_req <= 1'b1;
    @(posedge clk);
    ep_event <= '0;
    ext_resume_req <= 1'b0;
    isr = isr | (f & 32'h0000_003F) | 32'h0000_0400;
    @(posedge clk);
    rd(OFF_INT_STATUS);
    wr(OFF_INT_CLEAR, 32'h0000_3F3F);
    wr(OFF_INT_ENABLE, 32'h0000_0100);
    host.set_active(1'b0);
    wait_lvl(1'b0, 1'b1);
    isr = isr | 32'h0000_0100;
    rd(OFF_INT_STATUS);
    wr(OFF_INT_CLEAR, 32'h0000_0100);
    chk(32'(port_suspended), 32'h0000_0001);
    wr(OFF_XCVR_CTRL, 32'h0000_0300);
    host.set_active(1'b1);
    wait_lvl(1'b1, 1'b0);
    isr = isr | 32'h0000_2200;
    rd(OFF_INT_STATUS);
    wr(OFF_INT_DISABLE, 32'h0000_2F3F);
    rd(OFF_INT_STATUS);
    wr(OFF_XCVR_CTRL, 32'h0000_0200);
    rd(OFF_INT_MASK);
    wr(OFF_INT_CLEAR, 32'h0000_3F3F);
    wr(OFF_INT_ENABLE, 32'h0000_2100);
    host.set_active(1'b0);
    wait_lvl(1'b0, 1'b1);
    wr(OFF_INT_CLEAR, 32'h0000_0100);
    host.remote_wakeup(SUSP, 4);
    wait_lvl(1'b1, 1'b0);
    isr = isr | 32'h0000_2200;
    rd(OFF_INT_STATUS);
    stop_test();
  end
endmodule
